// ==== inc/psl_pkg.sv ====
package psl_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned SHORT_MS = 20;
    localparam int unsigned LONG_MS = 80;
    localparam int unsigned PERIOD_MS = SHORT_MS + LONG_MS;
    localparam int unsigned MS_W = 7;

    // ---------------------------------------------------------------
    // status carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic link_up;
        logic activity;
        logic speed_100;
        logic full_duplex;
        logic collision;
    } psl_port_t;

    typedef struct packed {
        logic link_up;
        logic speed_100;
        logic full_duplex;
    } psl_remote_t;

    typedef struct packed {
        logic running;
        logic done;
        logic pass;
    } psl_test_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_DONE = 3'b100
    } psl_lb_state_t;
endpackage

// ==== src/psl_led_driver.sv ====
// Overview of operation
// - copper link LED: on if up, off if down, 20/80ms flash on traffic
// - copper speed LED on at 100M, off at 10M
// - copper duplex LED on full, off half, 20/80ms flash on collision
// - fiber link LED: on if up, off if down, 20/80ms flash on traffic
// - fiber duplex LED on full, off half, 20/80ms flash on collision
// - fiber signal LED follows the signal-detect input
// - far fault LED flashes on 80ms off 20ms while fault received
// - remote link LED shows remote link, or 80/20ms flash in auto-test
// - remote speed LED shows remote speed, or off during test, on done
// - remote duplex LED shows remote duplex, or test pass result
// - all LED outputs active low
// - rising strap edge starts one loop-back test
`timescale 1ns/100ps
`default_nettype none
module psl_led_driver #(
    parameter int unsigned MS_DIV = psl_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // local port status
    input var psl_pkg::psl_port_t copper_i,
    input var psl_pkg::psl_port_t fiber_i,
    input wire logic fiber_signal_detect_in_i,
    input wire logic far_fault_rx_i,
    // remote status and loop-back test
    input var psl_pkg::psl_remote_t remote_i,
    input wire logic auto_test_i,
    input wire logic test_done_i,
    input wire logic test_pass_i,
    output logic test_start_o,
    // indicators, low lights the led
    output logic copper_link_indicator_n_o,
    output logic copper_speed_indicator_n_o,
    output logic copper_duplex_indicator_n_o,
    output logic fiber_link_indicator_n_o,
    output logic fiber_duplex_indicator_n_o,
    output logic fiber_signal_indicator_n_o,
    output logic far_fault_indicator_n_o,
    output logic remote_link_indicator_n_o,
    output logic remote_speed_indicator_n_o,
    output logic remote_duplex_indicator_n_o
);
    import psl_pkg::*;

    // prescaler width, sets the largest divisor the timebase can take
    localparam int unsigned PRE_W = 24;

    // a zero divisor or one beyond the prescaler cannot be counted
    if (MS_DIV < 1 || MS_DIV >= 2 ** PRE_W) begin : g_bad_div
        $error("MS_DIV out of range");
    end

    // ---------------------------------------------------------------
    // millisecond timebase
    // ---------------------------------------------------------------
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [MS_W-1:0] ms_q, ms_d;
    // tick marks the last prescaler count of each millisecond
    wire ms_tick = (pre_q == PRE_W'(MS_DIV - 1));
    wire ms_wrap = (ms_q == MS_W'(PERIOD_MS - 1));

    // prescaler counts clock cycles up to one millisecond
    assign pre_d = ms_tick ? PRE_W'(0) : pre_q + PRE_W'(1);
    // the phase moves once a millisecond and wraps after one flash period
    assign ms_d = !ms_tick ? ms_q
                : ms_wrap ? MS_W'(0)
                : ms_q + MS_W'(1);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_q <= PRE_W'(0);
        end else begin
            pre_q <= pre_d;
        end
    end

    // reset puts the phase back at the dark-to-lit boundary
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ms_q <= MS_W'(0);
        end else begin
            ms_q <= ms_d;
        end
    end

    // phase 0 starts the lit part, so every flash opens lit after reset
    wire flash_short = (ms_q < MS_W'(SHORT_MS));
    wire flash_long = (ms_q < MS_W'(LONG_MS));

    // ---------------------------------------------------------------
    // loop-back test sequencing
    // ---------------------------------------------------------------
    psl_lb_state_t st_q, st_d;
    logic strap_q;
    logic pass_q, pass_d;
    // strap state before reset release is taken as low
    wire strap_rise = auto_test_i & ~strap_q;

    // idle until the first strap rise, run until the engine reports done,
    // done holds the result until the strap rises once more
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: if (strap_rise) st_d = ST_RUN;
            ST_RUN: if (test_done_i) st_d = ST_DONE;
            ST_DONE: if (strap_rise) st_d = ST_RUN;
            default: st_d = ST_IDLE;
        endcase
    end

    // edge detector on the strap, and the start pulse it raises
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_q <= 1'b0;
            test_start_o <= 1'b0;
        end else begin
            strap_q <= auto_test_i;
            test_start_o <= strap_rise;
        end
    end

    // state moves only on strap rises and done reports
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // a done report outside a running test is dropped, result kept
    wire take_result = (st_q == ST_RUN) & test_done_i;
    assign pass_d = take_result ? test_pass_i : pass_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pass_q <= 1'b0;
        end else begin
            pass_q <= pass_d;
        end
    end

    wire test_complete = (st_q == ST_DONE);

    // ---------------------------------------------------------------
    // indicator decode, 1 = lit
    // ---------------------------------------------------------------
    // both ports share one decode, so their flashes stay in step
    function automatic logic link_led(input psl_port_t p, input logic fl);
        return p.link_up & ~(p.activity & ~fl);
    endfunction

    function automatic logic dup_led(input psl_port_t p, input logic fl);
        return p.full_duplex | (p.collision & fl);
    endfunction

    wire cu_link_on = link_led(copper_i, flash_short);
    wire cu_spd_on = copper_i.speed_100;
    wire cu_dup_on = dup_led(copper_i, flash_short);
    wire fx_link_on = link_led(fiber_i, flash_short);
    wire fx_dup_on = dup_led(fiber_i, flash_short);
    wire fx_sd_on = fiber_signal_detect_in_i;
    wire fef_on = far_fault_rx_i & flash_long;
    wire rm_link_on = auto_test_i ? flash_long : remote_i.link_up;
    wire rm_spd_on = auto_test_i ? test_complete
                                 : remote_i.speed_100;
    wire rm_dup_on = auto_test_i ? (test_complete & pass_q)
                                 : remote_i.full_duplex;

    // ---------------------------------------------------------------
    // copper indicators
    // ---------------------------------------------------------------
    // registered so the pins never glitch while the decode settles
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            copper_link_indicator_n_o <= 1'b1;
            copper_speed_indicator_n_o <= 1'b1;
            copper_duplex_indicator_n_o <= 1'b1;
        end else begin
            copper_link_indicator_n_o <= ~cu_link_on;
            copper_speed_indicator_n_o <= ~cu_spd_on;
            copper_duplex_indicator_n_o <= ~cu_dup_on;
        end
    end

    // ---------------------------------------------------------------
    // fiber indicators
    // ---------------------------------------------------------------
    // far fault rides with the fiber group, it is a fiber receive event
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fiber_link_indicator_n_o <= 1'b1;
            fiber_duplex_indicator_n_o <= 1'b1;
            fiber_signal_indicator_n_o <= 1'b1;
            far_fault_indicator_n_o <= 1'b1;
        end else begin
            fiber_link_indicator_n_o <= ~fx_link_on;
            fiber_duplex_indicator_n_o <= ~fx_dup_on;
            fiber_signal_indicator_n_o <= ~fx_sd_on;
            far_fault_indicator_n_o <= ~fef_on;
        end
    end

    // ---------------------------------------------------------------
    // remote indicators
    // ---------------------------------------------------------------
    // in auto-test these carry the test-mode flash and the loop-back progress, not remote state
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            remote_link_indicator_n_o <= 1'b1;
            remote_speed_indicator_n_o <= 1'b1;
            remote_duplex_indicator_n_o <= 1'b1;
        end else begin
            remote_link_indicator_n_o <= ~rm_link_on;
            remote_speed_indicator_n_o <= ~rm_spd_on;
            remote_duplex_indicator_n_o <= ~rm_dup_on;
        end
    end
endmodule // psl_led_driver
`default_nettype wire

// ==== verif/psl_led_bank.sv ====
`timescale 1ns/100ps
`default_nettype none
module psl_led_bank (
    input wire logic [9:0] pin_n_i,
    output logic [9:0] lit_o
);
    assign lit_o = ~pin_n_i;
endmodule // psl_led_bank
`default_nettype wire

// ==== verif/psl_chk_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module psl_chk #(
    parameter int unsigned MS_DIV = psl_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched inputs
    input var psl_pkg::psl_port_t copper_i,
    input var psl_pkg::psl_remote_t remote_i,
    input wire logic far_fault_rx_i,
    input wire logic auto_test_i,
    // watched outputs
    input wire logic test_start_o,
    input wire logic copper_link_indicator_n_o,
    input wire logic copper_speed_indicator_n_o,
    input wire logic copper_duplex_indicator_n_o,
    input wire logic far_fault_indicator_n_o,
    input wire logic remote_link_indicator_n_o
);
    localparam int unsigned REF_SPAN = psl_pkg::PERIOD_MS * MS_DIV;
    localparam int unsigned REF_SHORT = psl_pkg::SHORT_MS * MS_DIV;
    localparam int unsigned REF_LONG = psl_pkg::LONG_MS * MS_DIV;
    psl_pkg::psl_port_t c_q;
    psl_pkg::psl_remote_t r_q;
    logic up_q, sh_q, lg_q, x_q, a_q;
    int unsigned q;
    // reference phase, must restart with the design's timebase
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_q <= 1'b0;
            q <= 0;
        end else begin
            up_q <= 1'b1;
            q <= (q == REF_SPAN - 1) ? 0 : q + 1;
            {c_q, r_q, x_q, a_q} <= {copper_i, remote_i, far_fault_rx_i,
                auto_test_i};
            sh_q <= (q < REF_SHORT);
            lg_q <= (q < REF_LONG);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_CL: assert property (
        up_q |-> copper_link_indicator_n_o
            == !(c_q.link_up && (!c_q.activity || sh_q)))
        else $error("cu link");
    AST_CS: assert property (
        up_q |-> copper_speed_indicator_n_o == !c_q.speed_100)
        else $error("cu speed");
    AST_CD: assert property (
        up_q |-> copper_duplex_indicator_n_o
            == !(c_q.full_duplex || (c_q.collision && sh_q)))
        else $error("cu dup");
    AST_FF: assert property (
        up_q |-> far_fault_indicator_n_o == !(x_q && lg_q))
        else $error("far fault");
    AST_RL: assert property (
        up_q && !a_q |-> remote_link_indicator_n_o == !r_q.link_up)
        else $error("remote link");
    AST_RT: assert property (
        up_q && a_q |-> remote_link_indicator_n_o == !lg_q)
        else $error("remote flash");
    AST_GO: assert property ($rose(auto_test_i) |=> test_start_o)
        else $error("no start");
    AST_NG: assert property (!$rose(auto_test_i) |=> !test_start_o)
        else $error("stray start");
endmodule // psl_chk
`default_nettype wire

// ==== verif/test_psl_led_driver.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_psl_led_driver;
    import psl_pkg::*;
    localparam int DIV = 2;
    logic clk_i = 1'b0, rst_i = 1'b1, sd = 1'b0, ff = 1'b0, at = 1'b0;
    logic dn = 1'b0, ps = 1'b0, st;
    psl_port_t cu = '0, fi = '0;
    psl_remote_t rm = '0;
    wire [9:0] pn;
    wire [9:0] lit;
    logic [9:0] a, b;
    int fails = 0, cmp_count = 0, i, k[10];
    always #5 clk_i = ~clk_i;
    psl_led_driver #(.MS_DIV(DIV)) DUT (.clk_i, .rst_i, .copper_i(cu),
        .fiber_i(fi), .fiber_signal_detect_in_i(sd), .far_fault_rx_i(ff),
        .remote_i(rm), .auto_test_i(at), .test_done_i(dn), .test_pass_i(ps),
        .test_start_o(st), .copper_link_indicator_n_o(pn[9]),
        .copper_speed_indicator_n_o(pn[8]),
        .copper_duplex_indicator_n_o(pn[7]),
        .fiber_link_indicator_n_o(pn[6]), .fiber_duplex_indicator_n_o(pn[5]),
        .fiber_signal_indicator_n_o(pn[4]), .far_fault_indicator_n_o(pn[3]),
        .remote_link_indicator_n_o(pn[2]), .remote_speed_indicator_n_o(pn[1]),
        .remote_duplex_indicator_n_o(pn[0]));
    psl_led_bank LEDS (.pin_n_i(pn), .lit_o(lit));
    task automatic chk(input string n, input logic [9:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
        $display("test %s done", n);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic run(input logic p);
        @(posedge clk_i);
        at <= 1'b1;
        tk(1);
        chk("start", {9'h0, st}, 10'h001);
        @(posedge clk_i);
        {dn, ps} <= {1'b1, p};
        #1 chk("running", lit & 10'h003, 10'h000);
        @(posedge clk_i);
        dn <= 1'b0;
        tk(3);
        chk("result", lit & 10'h003, {9'h1, p});
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        {cu, fi, sd, rm} <= {5'h16, 5'h12, 1'b1, 3'h7};
        tk(3);
        chk("steady", lit, 10'h3f7);
        @(posedge clk_i);
        {cu, fi, sd, rm} <= 14'h0000;
        tk(3);
        chk("dark", lit, 10'h000);
        run(1'b1);
        @(posedge clk_i);
        {cu, fi, ff} <= {5'h19, 5'h19, 1'b1};
        tk(2);
        k = '{default: 0};
        // one whole period, so the count holds at any phase
        repeat (PERIOD_MS * DIV) begin
            tk(1);
            for (i = 0; i < 10; i++) k[i] += lit[i];
        end
        for (i = 0; i < 10; i++) begin
            a[i] = (k[i] == SHORT_MS * DIV);
            b[i] = (k[i] == LONG_MS * DIV);
        end
        chk("short", a, 10'h2e0);
        chk("long", b, 10'h00c);
        @(posedge clk_i);
        {cu, fi, ff, at, rm} <= {10'h0, 1'b0, 1'b0, 3'h5};
        tk(3);
        chk("remote", lit, 10'h005);
        run(1'b0);
        // a done report after the test has finished must be ignored
        @(posedge clk_i);
        {dn, ps} <= 2'b11;
        @(posedge clk_i);
        dn <= 1'b0;
        tk(3);
        chk("late done", lit & 10'h003, 10'h002);
        @(posedge clk_i);
        {rst_i, at, cu} <= {2'b10, 5'h19};
        tk(1);
        chk("reset", lit, 10'h000);
        @(posedge clk_i);
        rst_i <= 1'b0;
        tk(1);
        chk("restart", lit, 10'h285);
        stop_test();
    end
endmodule // test_psl_led_driver
bind psl_led_driver psl_chk #(.MS_DIV(MS_DIV)) u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .copper_i(copper_i),
    .remote_i(remote_i),
    .far_fault_rx_i(far_fault_rx_i),
    .auto_test_i(auto_test_i),
    .test_start_o(test_start_o),
    .copper_link_indicator_n_o(copper_link_indicator_n_o),
    .copper_speed_indicator_n_o(copper_speed_indicator_n_o),
    .copper_duplex_indicator_n_o(copper_duplex_indicator_n_o),
    .far_fault_indicator_n_o(far_fault_indicator_n_o),
    .remote_link_indicator_n_o(remote_link_indicator_n_o)
);
`default_nettype wire
